// >>> gpio_exp_pkg.sv
// Constants, types and register layout shared by the I/O expander files.
// Assumes a single 125 MHz register clock; the serial link is sampled on it.
package gpio_exp_pkg;

	localparam int NBANK  = 3;
	localparam int BANK_W = 8;
	localparam int NPINS  = NBANK * BANK_W;
	localparam int STS_W  = 4;

	// Register kind, taken from bits [3:2] of a register index.
	localparam logic [1:0] KIND_IN  = 2'h0;
	localparam logic [1:0] KIND_OUT = 2'h1;
	localparam logic [1:0] KIND_POL = 2'h2;
	localparam logic [1:0] KIND_DIR = 2'h3;

	// Bus byte offsets outside the per-bank block at 8'h00 to 8'h3c.
	localparam logic [7:0] OFF_STATUS = 8'h40;
	localparam logic [7:0] OFF_MASK   = 8'h44;

	// Status bit positions: banks 0 to 2 changed, serial write done.
	localparam int STS_SERIAL_WR = 3;

	// Values after reset; a direction bit of one means input.
	localparam logic [23:0] DIR_RST   = 24'hffffff;
	localparam logic [23:0] OUT_RST   = 24'hffffff;
	localparam logic [23:0] POL_RST   = 24'h000000;
	localparam logic [23:0] INREG_RST = 24'h000000;
	localparam logic [3:0]  STS_RST   = 4'h0;
	localparam logic [3:0]  MASK_RST  = 4'h0;

	// Bus slave phases.
	typedef enum logic [1:0] {
		PH_IDLE    = 2'b00,
		PH_WR      = 2'b01,
		PH_RD_WAIT = 2'b10,
		PH_RD_DONE = 2'b11
	} ahb_ph_t;

	// Serial target states.
	typedef enum logic [2:0] {
		SER_IDLE   = 3'b000,
		SER_RX     = 3'b001,
		SER_RX_ACK = 3'b010,
		SER_TX     = 3'b011,
		SER_TX_ACK = 3'b100
	} ser_st_t;

	// Register write request from the serial target.
	typedef struct packed {
		logic       stb;
		logic [3:0] idx;
		logic [7:0] data;
	} reg_wr_t;

	// The register file and its event history.
	typedef struct packed {
		logic [23:0] dir;
		logic [23:0] outv;
		logic [23:0] pol;
		logic [23:0] inreg;
		logic [3:0]  sts;
		logic [3:0]  mask;
		logic [2:0]  alert_q;
	} regs_t;

	localparam regs_t REGS_RST = '{dir: DIR_RST, outv: OUT_RST, pol: POL_RST,
		inreg: INREG_RST, sts: STS_RST, mask: MASK_RST, alert_q: 3'h0};

endpackage : gpio_exp_pkg

// >>> gpio_expander.sv
// Top of the 24-pin I/O expander: register file on an AHB-Lite slave and a serial target.
// Assumes port pins, reset pin, strap and serial lines are asynchronous to hclk.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// R1 - Three 8-bit banks each of direction, input, output and polarity registers.
// R2 - After reset every pin is an input with its driver off.
// R3 - Direction bit written by the controller makes a pin drive or release.
// R4 - Input register holds sampled pin levels; output register holds driven levels.
// R5 - A set polarity bit reports the complemented pin level in the input register.
// R6 - Every register can be read back.
// R7 - The controller may force a reset by pulling the reset pin low.
// R8 - Power-on reset defaults all registers and idles the serial state machine.
// R9 - The reset pin defaults all registers, drops alert and idles the serial state machine; bus read data and serial pointer keep their values.
// R10 - Alert asserts when any input pin differs from its input register value.
// R11 - Alert is open-drain and active low.
// R12 - One target address bit comes from a strapped select pin.
// R13 - Each pin is bidirectional and drives push-pull in output mode.
// R14 - The serial target works at bus clocks up to fast mode.
// R15 - Output pins keep their last written value until the next write.
// R16 - After reset the controller waits the recovery time before a start.
// R17 - Alert drops when the bank is read or inputs return.
// R18 - Polarity inversion never changes the driven output level.
module gpio_expander #(
	parameter logic [6:0] TARGET_ADDR = 7'h22
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        rst_pin_n,
	input  wire logic        addr_sel,
	input  wire logic        scl_pin,
	input  wire logic        sda_pin_in,
	output logic             sda_pin_out,
	output logic             sda_pin_oe,
	input  wire logic [23:0] port_pins_in,
	output logic [23:0]      port_pins_out,
	output logic [23:0]      port_pins_oe,
	output logic             alert_n_out,
	output logic             alert_n_oe,
	output logic             irq
);

	typedef struct packed {
		logic [1:0]           rstp_s;
		logic [23:0]          port_s0;
		logic [23:0]          port_s1;
		gpio_exp_pkg::ahb_ph_t ph;
		logic [7:0]           addr;
		logic [31:0]          rdata;
		logic                 alert_oe;
		gpio_exp_pkg::regs_t  regs;
	} top_state_t;

	localparam top_state_t TOP_RST = '{rstp_s: 2'h0, port_s0: 24'h0, port_s1: 24'h0,
		ph: gpio_exp_pkg::PH_IDLE, addr: 8'h0, rdata: 32'h0, alert_oe: 1'b0,
		regs: gpio_exp_pkg::REGS_RST};

	top_state_t            q;
	top_state_t            n;
	logic                  soft_rst;
	logic                  accept;
	logic [23:0]           cur;
	logic [2:0]            bank_alert;
	logic [3:0]            ser_ptr;
	logic [7:0]            ser_rd_data;
	logic                  ser_rd_stb;
	logic [3:0]            ser_rd_idx;
	gpio_exp_pkg::reg_wr_t ser_wr;

	// Register index is kind in [3:2] and bank in [1:0]; bank 3 does not exist.
	function automatic logic idx_valid(input logic [3:0] idx);
		idx_valid = (idx[1:0] != 2'h3);
	endfunction : idx_valid

	// R6 read back
	function automatic logic [7:0] reg_read(input gpio_exp_pkg::regs_t r,
		input logic [23:0] c, input logic [3:0] idx);
		logic [4:0] b;
		b = {idx[1:0], 3'b000};
		reg_read = 8'h00;
		if (idx_valid(idx)) begin
			case (idx[3:2])
				gpio_exp_pkg::KIND_IN:  reg_read = c[b +: 8];
				gpio_exp_pkg::KIND_OUT: reg_read = r.outv[b +: 8];
				gpio_exp_pkg::KIND_POL: reg_read = r.pol[b +: 8];
				default:                reg_read = r.dir[b +: 8];
			endcase
		end
	endfunction : reg_read

	// R1 banked registers
	function automatic gpio_exp_pkg::regs_t reg_write(input gpio_exp_pkg::regs_t r,
		input logic [3:0] idx, input logic [7:0] d);
		logic [4:0] b;
		b = {idx[1:0], 3'b000};
		reg_write = r;
		if (idx_valid(idx)) begin
			case (idx[3:2])
				gpio_exp_pkg::KIND_OUT: reg_write.outv[b +: 8] = d;
				gpio_exp_pkg::KIND_POL: reg_write.pol[b +: 8] = d;
				gpio_exp_pkg::KIND_DIR: reg_write.dir[b +: 8] = d;
				default:                reg_write = r;
			endcase
		end
	endfunction : reg_write

	// Reading an input bank latches its current value, which clears its alert.
	function automatic gpio_exp_pkg::regs_t snap(input gpio_exp_pkg::regs_t r,
		input logic [23:0] c, input logic [3:0] idx);
		logic [4:0] b;
		b = {idx[1:0], 3'b000};
		snap = r;
		if (idx_valid(idx) && idx[3:2] == gpio_exp_pkg::KIND_IN) begin
			snap.inreg[b +: 8] = c[b +: 8];
		end
	endfunction : snap

	// R7 external reset
	assign soft_rst = ~q.rstp_s[1];
	assign accept   = hsel & hready & htrans[1];
	// R5 polarity view
	// R18 inputs only
	assign cur      = q.port_s1 ^ q.regs.pol;

	// R10 change detect
	genvar g;
	generate
		for (g = 0; g < gpio_exp_pkg::NBANK; g++) begin : g_bank
			assign bank_alert[g] = |((cur[g*8 +: 8] ^ q.regs.inreg[g*8 +: 8])
				& q.regs.dir[g*8 +: 8]);
		end
	endgenerate

	assign ser_rd_data = reg_read(q.regs, cur, ser_ptr);

	always_comb begin
		n = q;
		n.rstp_s = {q.rstp_s[0], rst_pin_n};
		n.port_s0 = port_pins_in;
		n.port_s1 = q.port_s0;
		if (accept) begin
			n.addr = haddr[7:0];
			n.ph = hwrite ? gpio_exp_pkg::PH_WR : gpio_exp_pkg::PH_RD_WAIT;
		end else if (q.ph == gpio_exp_pkg::PH_RD_WAIT) begin
			n.ph = gpio_exp_pkg::PH_RD_DONE;
		end else begin
			n.ph = gpio_exp_pkg::PH_IDLE;
		end
		// R4 serial side
		if (ser_wr.stb) begin
			n.regs = reg_write(n.regs, ser_wr.idx, ser_wr.data);
		end
		if (ser_rd_stb) begin
			n.regs = snap(n.regs, cur, ser_rd_idx);
		end
		// R3 bus writes
		if (q.ph == gpio_exp_pkg::PH_WR) begin
			if (q.addr == gpio_exp_pkg::OFF_MASK) begin
				n.regs.mask = hwdata[3:0];
			end else if (q.addr[7:6] == 2'b00 && q.addr[1:0] == 2'b00) begin
				n.regs = reg_write(n.regs, q.addr[5:2], hwdata[7:0]);
			end
		end
		if (q.ph == gpio_exp_pkg::PH_RD_WAIT) begin
			if (q.addr == gpio_exp_pkg::OFF_STATUS) begin
				n.rdata = {28'h0, q.regs.sts};
				n.regs.sts = gpio_exp_pkg::STS_RST;
			end else if (q.addr == gpio_exp_pkg::OFF_MASK) begin
				n.rdata = {28'h0, q.regs.mask};
			end else if (q.addr[7:6] == 2'b00 && q.addr[1:0] == 2'b00) begin
				n.rdata = {24'h0, reg_read(q.regs, cur, q.addr[5:2])};
				// R17 read clears
				n.regs = snap(n.regs, cur, q.addr[5:2]);
			end else begin
				n.rdata = 32'h0;
			end
		end
		// New events are applied after the read clear so that a set wins.
		n.regs.alert_q = bank_alert;
		n.regs.sts[2:0] = n.regs.sts[2:0] | (bank_alert & ~q.regs.alert_q);
		if (ser_wr.stb) begin
			n.regs.sts[gpio_exp_pkg::STS_SERIAL_WR] = 1'b1;
		end
		n.alert_oe = |bank_alert;
		// R9 registers and alert back to power-on values
		if (soft_rst) begin
			n.regs = gpio_exp_pkg::REGS_RST;
			n.alert_oe = 1'b0;
		end
	end

	// R8 power-on defaults
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= TOP_RST;
		end else begin
			q <= n;
		end
	end

	serial_target #(
		.TARGET_ADDR (TARGET_ADDR)
	) u_serial (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.clear       (soft_rst),
		.scl_pin     (scl_pin),
		.sda_pin_in  (sda_pin_in),
		.addr_sel    (addr_sel),
		.rd_data     (ser_rd_data),
		.sda_pin_out (sda_pin_out),
		.sda_pin_oe  (sda_pin_oe),
		.ptr         (ser_ptr),
		.rd_stb      (ser_rd_stb),
		.rd_idx      (ser_rd_idx),
		.wr          (ser_wr)
	);

	// Reads take one wait state so that read data always leave a flip-flop.
	assign hreadyout = (q.ph != gpio_exp_pkg::PH_RD_WAIT);
	assign hresp     = 1'b0;
	assign hrdata    = q.rdata;

	// R13 push-pull drive
	// R15 latched outputs
	assign port_pins_out = q.regs.outv;
	// R2 inputs at reset
	assign port_pins_oe  = ~q.regs.dir;
	// R11 open drain
	assign alert_n_out   = 1'b0;
	assign alert_n_oe    = q.alert_oe;
	assign irq           = |(q.regs.sts & q.regs.mask);

	logic out_wr;
	assign out_wr = (q.ph == gpio_exp_pkg::PH_WR && q.addr[7:4] == 4'h1)
		|| (ser_wr.stb && ser_wr.idx[3:2] == gpio_exp_pkg::KIND_OUT);

	property p_reset_inputs;
		@(posedge hclk) disable iff (!hresetn)
		soft_rst |=> (port_pins_oe == 24'h000000) && !alert_n_oe;
	endproperty
	a_reset_inputs: assert property (p_reset_inputs) else $error("pins driven after reset"); // R9

	property p_dir_write;
		@(posedge hclk) disable iff (!hresetn)
		(q.ph == gpio_exp_pkg::PH_WR && q.addr == 8'h34 && !soft_rst && !ser_wr.stb)
			|=> port_pins_oe[15:8] == ~$past(hwdata[7:0]);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction write not applied"); // R3

	property p_out_write;
		@(posedge hclk) disable iff (!hresetn)
		(q.ph == gpio_exp_pkg::PH_WR && q.addr == 8'h14 && !soft_rst)
			|=> port_pins_out[15:8] == $past(hwdata[7:0]);
	endproperty
	a_out_write: assert property (p_out_write) else $error("output write not applied"); // R4

	property p_out_hold;
		@(posedge hclk) disable iff (!hresetn)
		(!out_wr && !soft_rst) |=> $stable(port_pins_out);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output changed without write"); // R15

	property p_pol_no_drive;
		@(posedge hclk) disable iff (!hresetn)
		(q.ph == gpio_exp_pkg::PH_WR && q.addr[7:4] == 4'h2 && !ser_wr.stb && !soft_rst)
			|=> $stable(port_pins_out);
	endproperty
	a_pol_no_drive: assert property (p_pol_no_drive) else $error("polarity moved output"); // R18

	property p_inv_read;
		@(posedge hclk) disable iff (!hresetn)
		(q.ph == gpio_exp_pkg::PH_RD_WAIT && q.addr == 8'h00)
			|=> hrdata[7:0] == ($past(q.port_s1[7:0]) ^ $past(q.regs.pol[7:0])) && hreadyout;
	endproperty
	a_inv_read: assert property (p_inv_read) else $error("input read wrong polarity"); // R5

	property p_readback;
		@(posedge hclk) disable iff (!hresetn)
		(q.ph == gpio_exp_pkg::PH_RD_WAIT && q.addr == 8'h38)
			|=> hrdata == {24'h0, $past(q.regs.dir[23:16])};
	endproperty
	a_readback: assert property (p_readback) else $error("direction read back wrong"); // R6

	property p_alert_on_change;
		@(posedge hclk) disable iff (!hresetn)
		(|bank_alert && !soft_rst) |=> alert_n_oe && !alert_n_out;
	endproperty
	a_alert_on_change: assert property (p_alert_on_change) else $error("alert missing"); // R10

	property p_alert_clears;
		@(posedge hclk) disable iff (!hresetn)
		(q.ph == gpio_exp_pkg::PH_RD_WAIT && q.addr == 8'h00 && !ser_wr.stb && !soft_rst)
			|=> !bank_alert[0] || !$stable(q.port_s1[7:0]);
	endproperty
	a_alert_clears: assert property (p_alert_clears) else $error("alert not cleared by read"); // R17

	c_alert: cover property (@(posedge hclk) disable iff (!hresetn) $rose(alert_n_oe));
	c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
	c_sda_drive: cover property (@(posedge hclk) disable iff (!hresetn) $rose(sda_pin_oe));

endmodule : gpio_expander
`default_nettype wire

// >>> gpio_expander_tb.sv
// Self-checking bench for the I/O expander: AHB-Lite register tasks and a serial peer.
// Assumes the expander's undriven pins follow a far side that the bench drives through ext_pins.
`timescale 1ns/10ps
`default_nettype none
module gpio_expander_tb;
	localparam logic [6:0] TADDR = 7'h22;

	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rst_pin_n, addr_sel;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        scl_pin, sda_pin_in, sda_pin_out, sda_pin_oe;
	logic [23:0] ext_pins, port_pins_in, port_pins_out, port_pins_oe;
	logic        alert_n_out, alert_n_oe, irq, ack, alert_line;
	logic [7:0]  sd;
	int          err_total, comparisons;

	// Pins read back what the device drives, otherwise the outside level.
	assign port_pins_in = (port_pins_oe & port_pins_out) | (~port_pins_oe & ext_pins);
	assign alert_line   = (alert_n_oe && alert_n_out === 1'b0) ? 1'b0 : 1'b1;

	gpio_expander #(.TARGET_ADDR(TADDR)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rst_pin_n(rst_pin_n),
		.addr_sel(addr_sel), .scl_pin(scl_pin), .sda_pin_in(sda_pin_in),
		.sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe), .port_pins_in(port_pins_in),
		.port_pins_out(port_pins_out), .port_pins_oe(port_pins_oe),
		.alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe), .irq(irq)
	);

	i2c_ctrl_model PEER (
		.sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe),
		.scl_pin(scl_pin), .sda_pin_in(sda_pin_in)
	);

	task automatic close_out;
		if (err_total == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One single transfer; read data is taken at the edge that ends the data phase.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		comparisons++;
		if (hresp !== 1'b0) begin
			err_total++;
			$display("ERROR at %0t: bus error response", $time);
		end
	endtask : ahb

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdc

	task automatic pins(input logic [23:0] oe, input logic [23:0] out);
		@(negedge hclk);
		chk({8'h00, port_pins_oe}, {8'h00, oe});
		chk({8'h00, port_pins_out}, {8'h00, out});
	endtask : pins

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	initial begin
		#200000;
		err_total++;
		close_out();
	end

	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, ext_pins} = '0;
		hsize = 3'h2;
		rst_pin_n = 1'b1;
		addr_sel = 1'b1;
		err_total = 0;
		comparisons = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		pins(24'h000000, 24'hffffff);
		chk({31'h0, alert_line}, 32'h1);
		for (int b = 0; b < 3; b++) begin
			rdc(8'h30 + 8'(4 * b), 32'hff);
			rdc(8'h10 + 8'(4 * b), 32'hff);
			rdc(8'h20 + 8'(4 * b), 32'h00);
		end
		rdc(8'h44, 32'h0);
		ahb(1'b1, 8'h34, 32'h0f);
		ahb(1'b1, 8'h14, 32'ha5);
		pins(24'h00f000, 24'hffa5ff);
		ahb(1'b1, 8'h24, 32'hff);
		pins(24'h00f000, 24'hffa5ff);
		@(posedge hclk);
		ext_pins <= 24'h3c00c3;
		ahb(1'b1, 8'h20, 32'h0f);
		rdc(8'h00, 32'hcc);
		rdc(8'h04, 32'h5f);
		rdc(8'h08, 32'h3c);
		ahb(1'b0, 8'h40, 32'h0);
		rdc(8'h40, 32'h0);
		chk({31'h0, alert_line}, 32'h1);
		ahb(1'b1, 8'h44, 32'h4);
		@(posedge hclk);
		ext_pins <= 24'h3d00c3;
		repeat (6) @(posedge hclk);
		chk({31'h0, alert_line}, 32'h0);
		chk({31'h0, irq}, 32'h1);
		ahb(1'b0, 8'h40, 32'h0);
		chk(rd & 32'h4, 32'h4);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		rdc(8'h08, 32'h3d);
		repeat (4) @(posedge hclk);
		chk({31'h0, alert_line}, 32'h1);
		ahb(1'b1, 8'h44, 32'h0);
		@(posedge hclk);
		ext_pins <= 24'h3c00c3;
		repeat (6) @(posedge hclk);
		chk({30'h0, alert_line, irq}, 32'h0);
		rdc(8'h08, 32'h3c);
		ahb(1'b0, 8'h40, 32'h0);
		rdc(8'h0c, 32'h0);
		rdc(8'h48, 32'h0);
		ahb(1'b1, 8'h3c, 32'h00);
		pins(24'h00f000, 24'hffa5ff);
		PEER.start();
		PEER.put({TADDR[6:1], 2'b00}, ack);
		chk({31'h0, ack}, 32'h0);
		PEER.stop();
		PEER.start();
		PEER.put({TADDR[6:1], 2'b10}, ack);
		chk({31'h0, ack}, 32'h1);
		PEER.put(8'h04, ack);
		PEER.put(8'h5a, ack);
		PEER.put(8'h3c, ack);
		chk({31'h0, ack}, 32'h1);
		PEER.stop();
		pins(24'h00f000, 24'hff3c5a);
		rdc(8'h10, 32'h5a);
		ahb(1'b0, 8'h40, 32'h0);
		chk(rd & 32'h8, 32'h8);
		PEER.start();
		PEER.put({TADDR[6:1], 2'b10}, ack);
		PEER.put(8'h04, ack);
		PEER.start();
		PEER.put({TADDR[6:1], 2'b11}, ack);
		PEER.get(1'b0, sd);
		chk({24'h0, sd}, 32'h5a);
		PEER.get(1'b1, sd);
		chk({24'h0, sd}, 32'h3c);
		PEER.stop();
		@(posedge hclk);
		rst_pin_n <= 1'b0;
		addr_sel <= 1'b0;
		repeat (4) @(posedge hclk);
		rst_pin_n <= 1'b1;
		repeat (4) @(posedge hclk);
		pins(24'h000000, 24'hffffff);
		rdc(8'h20, 32'h00);
		PEER.recover();
		PEER.start();
		PEER.put({TADDR[6:1], 2'b00}, ack);
		chk({31'h0, ack}, 32'h1);
		PEER.stop();
		close_out();
	end

endmodule : gpio_expander_tb
`default_nettype wire

// >>> i2c_ctrl_model.sv
// Behavioural two-wire bus controller facing the expander's serial target.
// Assumes pull-ups on both lines; the target only ever pulls SDA low.
`timescale 1ns/10ps
`default_nettype none
module i2c_ctrl_model #(
	parameter int HALF_NS    = 40,
	parameter int T_RESET_NS = 600
) (
	input  wire logic sda_pin_out,
	input  wire logic sda_pin_oe,
	output logic      scl_pin,
	output logic      sda_pin_in
);
	logic pull_low;

	// The line floats high unless one of the two parties pulls it low.
	assign sda_pin_in = !(pull_low || (sda_pin_oe && !sda_pin_out));

	initial begin
		scl_pin  = 1'b1;
		pull_low = 1'b0;
	end

	task automatic recover;
		#(T_RESET_NS);
	endtask : recover

	task automatic start;
		pull_low = 1'b0;
		#(HALF_NS);
		scl_pin = 1'b1;
		#(2 * HALF_NS);
		pull_low = 1'b1;
		#(2 * HALF_NS);
		scl_pin = 1'b0;
		#(HALF_NS);
	endtask : start

	task automatic stop;
		pull_low = 1'b1;
		#(HALF_NS);
		scl_pin = 1'b1;
		#(2 * HALF_NS);
		pull_low = 1'b0;
		#(2 * HALF_NS);
	endtask : stop

	task automatic bit_out(input logic b);
		pull_low = !b;
		#(HALF_NS);
		scl_pin = 1'b1;
		#(2 * HALF_NS);
		scl_pin = 1'b0;
		#(HALF_NS);
	endtask : bit_out

	task automatic bit_in(output logic b);
		pull_low = 1'b0;
		#(HALF_NS);
		scl_pin = 1'b1;
		#(HALF_NS);
		b = sda_pin_in;
		#(HALF_NS);
		scl_pin = 1'b0;
		#(HALF_NS);
	endtask : bit_in

	// Bytes go out most significant bit first; ack is the target's low.
	task automatic put(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(a);
		ack = !a;
	endtask : put

	task automatic get(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_in(d[i]);
		end
		bit_out(last);
	endtask : get

endmodule : i2c_ctrl_model
`default_nettype wire

// >>> serial_target.sv
// Two-wire serial target: address match, command byte, data bytes in and out.
// Assumes scl and sda arrive unsynchronised; both pass two flip-flops here.
`timescale 1ns/10ps
`default_nettype none
module serial_target #(
	parameter logic [6:0] TARGET_ADDR = 7'h22
) (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   clear,
	input  wire logic                   scl_pin,
	input  wire logic                   sda_pin_in,
	input  wire logic                   addr_sel,
	input  wire logic [7:0]             rd_data,
	output logic                        sda_pin_out,
	output logic                        sda_pin_oe,
	output logic [3:0]                  ptr,
	output logic                        rd_stb,
	output logic [3:0]                  rd_idx,
	output gpio_exp_pkg::reg_wr_t       wr
);

	typedef struct packed {
		logic [2:0]            scl_s;
		logic [2:0]            sda_s;
		logic [1:0]            adr_s;
		gpio_exp_pkg::ser_st_t st;
		logic [3:0]            bitcnt;
		logic [7:0]            sh;
		logic [3:0]            idx;
		logic                  addr_byte;
		logic                  cmd_byte;
		logic                  rw;
		logic                  oe;
		logic                  rd_stb;
		logic [3:0]            rd_idx;
		gpio_exp_pkg::reg_wr_t wr;
	} ser_state_t;

	localparam ser_state_t SER_RST = '{st: gpio_exp_pkg::SER_IDLE, default: '0};

	ser_state_t q;
	ser_state_t n;
	logic       rise;
	logic       fall;
	logic       start;
	logic       stop;
	logic       sda;

	// R14 oversampled link edges
	assign sda   = q.sda_s[1];
	assign rise  = q.scl_s[1] & ~q.scl_s[2];
	assign fall  = ~q.scl_s[1] & q.scl_s[2];
	assign start = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~sda;
	assign stop  = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & sda;

	always_comb begin
		n = q;
		n.scl_s = {q.scl_s[1:0], scl_pin};
		n.sda_s = {q.sda_s[1:0], sda_pin_in};
		n.adr_s = {q.adr_s[0], addr_sel};
		n.rd_stb = 1'b0;
		n.wr.stb = 1'b0;
		// R9 serial reset
		if (clear) begin
			n.st = gpio_exp_pkg::SER_IDLE;
			n.oe = 1'b0;
		end else if (start) begin
			n.st = gpio_exp_pkg::SER_RX;
			n.bitcnt = 4'h0;
			n.addr_byte = 1'b1;
			n.oe = 1'b0;
		end else if (stop) begin
			n.st = gpio_exp_pkg::SER_IDLE;
			n.oe = 1'b0;
		end else begin
			case (q.st)
				gpio_exp_pkg::SER_RX: begin
					if (rise && q.bitcnt < 4'h8) begin
						n.sh = {q.sh[6:0], sda};
						n.bitcnt = q.bitcnt + 4'h1;
					end
					if (fall && q.bitcnt == 4'h8) begin
						n.st = gpio_exp_pkg::SER_RX_ACK;
						n.oe = 1'b1;
						if (q.addr_byte) begin
							n.addr_byte = 1'b0;
							n.rw = q.sh[0];
							n.cmd_byte = ~q.sh[0];
							// R12 strapped address
							if (q.sh[7:1] != {TARGET_ADDR[6:1], q.adr_s[1]}) begin
								n.st = gpio_exp_pkg::SER_IDLE;
								n.oe = 1'b0;
							end
						end else if (q.cmd_byte) begin
							n.cmd_byte = 1'b0;
							n.idx = q.sh[3:0];
						end else begin
							n.wr = '{stb: 1'b1, idx: q.idx, data: q.sh};
							n.idx = q.idx + 4'h1;
						end
					end
				end
				gpio_exp_pkg::SER_RX_ACK: begin
					if (fall) begin
						n.oe = 1'b0;
						n.bitcnt = 4'h0;
						n.st = gpio_exp_pkg::SER_RX;
						if (q.rw) begin
							n.st = gpio_exp_pkg::SER_TX;
							n.sh = rd_data;
							n.oe = ~rd_data[7];
							n.bitcnt = 4'h1;
							n.rd_stb = 1'b1;
							n.rd_idx = q.idx;
							n.idx = q.idx + 4'h1;
						end
					end
				end
				gpio_exp_pkg::SER_TX: begin
					if (fall && q.bitcnt < 4'h8) begin
						n.sh = {q.sh[6:0], 1'b0};
						n.oe = ~q.sh[6];
						n.bitcnt = q.bitcnt + 4'h1;
					end else if (fall) begin
						n.oe = 1'b0;
						n.st = gpio_exp_pkg::SER_TX_ACK;
					end
				end
				gpio_exp_pkg::SER_TX_ACK: begin
					if (rise) begin
						n.st = sda ? gpio_exp_pkg::SER_IDLE : gpio_exp_pkg::SER_RX_ACK;
					end
				end
				default: begin
					n.oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= SER_RST;
		end else begin
			q <= n;
		end
	end

	assign sda_pin_out = 1'b0;
	assign sda_pin_oe  = q.oe;
	assign ptr         = q.idx;
	assign rd_stb      = q.rd_stb;
	assign rd_idx      = q.rd_idx;
	assign wr          = q.wr;

	property p_no_ack_foreign;
		@(posedge hclk) disable iff (!hresetn)
		(q.st == gpio_exp_pkg::SER_RX && fall && q.bitcnt == 4'h8 && q.addr_byte && !clear
			&& !start && !stop && q.sh[7:1] != {TARGET_ADDR[6:1], q.adr_s[1]}) |=> !sda_pin_oe;
	endproperty
	a_no_ack_foreign: assert property (p_no_ack_foreign) else $error("acked a foreign address"); // R12

	c_serial_write: cover property (@(posedge hclk) disable iff (!hresetn) wr.stb);

endmodule : serial_target
`default_nettype wire
